// ---- design/wst_cmp.sv ----
/*
  One compare channel: matches a selectable slice of the counter against a
  compare value and pulses once, in the cycle after the first cycle of each match.
  Assumes cnt is the registered counter on the same clock.
*/
module wst_cmp #(
  parameter int CW = 56,
  parameter int DW = 32
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rstn,
  input  wire logic [CW-1:0]         cnt,
  input  wire logic [DW-1:0]         cmp_val,
  input  wire wst_pkg::wst_cmp_cfg_s cfg,
  output logic                       evt
);
  import wst_pkg::*;

  localparam logic [SIZE_W-1:0] TOP = SIZE_W'(DW - 1);

  logic [CW-1:0] shifted_w;
  logic [DW-1:0] mask_w;
  logic          match_w;
  logic          match_q;
  logic          evt_q;

  assign shifted_w = cnt >> cfg.start;
  assign mask_w    = {DW{1'b1}} >> (TOP - cfg.size);
  assign match_w   = ((shifted_w[DW-1:0] ^ cmp_val) & mask_w) == '0;

  // At half rate a match lasts two cycles; the edge keeps it to one event.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      match_q <= 1'b0;
      evt_q   <= 1'b0;
    end else begin
      match_q <= match_w;
      evt_q   <= match_w & ~match_q;
    end
  end

  assign evt = evt_q;

endmodule : wst_cmp

// ---- design/wst_pkg.sv ----
/*
  Shared constants and carrier types for the wide system timer: register offsets,
  field positions, reset values and the register bus request struct.
  Assumes a single 100 MHz ref_clk domain and byte addressing on the register port.
*/
package wst_pkg;

  localparam int CNT_W       = 56;
  localparam int DATA_W      = 32;
  localparam int ADDR_W      = 8;
  localparam int N_VIEWS     = 7;
  localparam int N_CMP       = 2;
  localparam int VIEW_STEP   = 4;
  localparam int CAP_SHIFT   = 32;
  localparam int CAP_W       = CNT_W - CAP_SHIFT;
  localparam int SIZE_W      = 5;
  localparam int START_W     = 6;
  localparam int CMCON_STRIDE = 16;
  localparam int CMCON_START  = 8;
  localparam int SYS_FREQ_MAX_MHZ = 80;

  localparam logic [ADDR_W-1:0] OFS_CLC   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_EXCL  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_VIEW0 = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_VIEW6 = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_CAP   = 8'h2c;
  localparam logic [ADDR_W-1:0] OFS_CMP0  = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_CMCON = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_STS   = 8'h3c;
  localparam logic [ADDR_W-1:0] OFS_MASK  = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_SRC0  = 8'h44;
  localparam logic [ADDR_W-1:0] REG_STEP  = 8'h04;

  localparam logic [DATA_W-1:0] CMCON_RESET = 32'h001f_001f;

  typedef struct packed {
    logic full_rate;
    logic susp_en;
    logic dis;
  } wst_clc_s;

  localparam wst_clc_s CLC_RESET = 3'h0;

  typedef struct packed {
    logic [START_W-1:0] start;
    logic [SIZE_W-1:0]  size;
  } wst_cmp_cfg_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } wst_bus_s;

endpackage : wst_pkg

// ---- design/wst_tick.sv ----
/*
  Timer clock enable generator: one tick per ref_clk at full rate, one every
  second ref_clk at half rate, none while the timer clock is stopped.
  Assumes run and full_rate come from logic on ref_clk.
*/
module wst_tick (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic run,
  input  wire logic full_rate,
  output logic      tick
);
  import wst_pkg::*;

  logic phase_q;
  logic tick_q;

  // Phase restarts when stopped so a restart always begins on a known phase.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      phase_q <= 1'b0;
      tick_q  <= 1'b0;
    end else begin
      phase_q <= run & ~phase_q;
      tick_q  <= run & (full_rate | phase_q);
    end
  end

  assign tick = tick_q;

endmodule : wst_tick

// ---- design/wst_timer.sv ----
/*
  Free-running 56-bit system timer with seven section views, an upper-part
  capture register, two compare channels with service requests and a masked
  interrupt. Assumes a register master on ref_clk, app_rst as a one-cycle pulse
  from ref_clk logic, and dbg_suspend from outside the clock domain.
*/
// Added by the designer: the register offsets and strobed register access.
// Overview of operation
// - The counter is 56 bits and steps once per timer clock tick.
// - Counting starts by itself after reset, no software write needed.
// - Application reset clears timer registers unless the exclusion bit is set; clock control, exclusion bit and service request enables keep their values.
// - Timer clock derives from system clock, half rate by default after reset.
// - Seven read-only 32-bit views show ever higher counter slices.
// - Reading any of the six lowest views captures the counter upper part.
// - Two compare channels match a chosen slice and raise service requests.
// - Clock control can switch the timer clock off or halt it on suspend.
// - While suspended the counter freezes but all registers stay readable.
module wst_timer (
  input  wire logic                       ref_clk,
  input  wire logic                       rstn,
  input  wire wst_pkg::wst_bus_s          bus,
  input  wire logic                       app_rst,
  input  wire logic                       dbg_suspend,
  output logic [wst_pkg::DATA_W-1:0]      rd_data,
  output logic                            irq,
  output logic [wst_pkg::N_CMP-1:0]       srq
);
  import wst_pkg::*;

  logic                 dbg_meta_q;
  logic                 dbg_sync_q;
  logic [CNT_W-1:0]     cnt_q;
  logic [CNT_W-1:0]     cnt_d;
  logic [CAP_W-1:0]     cap_q;
  logic [CAP_W-1:0]     cap_d;
  logic [DATA_W-1:0]    cmp_q [N_CMP];
  logic [DATA_W-1:0]    cmp_d [N_CMP];
  logic [DATA_W-1:0]    cmcon_q;
  logic [DATA_W-1:0]    cmcon_d;
  logic [N_CMP-1:0]     sts_q;
  logic [N_CMP-1:0]     sts_d;
  logic [N_CMP-1:0]     mask_q;
  logic [N_CMP-1:0]     mask_d;
  logic [N_CMP-1:0]     src_q;
  logic [N_CMP-1:0]     src_d;
  wst_clc_s             clc_q;
  wst_clc_s             clc_d;
  logic                 excl_q;
  logic                 excl_d;
  logic [DATA_W-1:0]    rdata_q;
  logic                 irq_q;
  logic [N_CMP-1:0]     srq_q;

  logic                 clr_w;
  logic                 run_w;
  logic                 tick_w;
  logic [N_CMP-1:0]     evt_w;
  logic [N_CMP-1:0]     sel_cmp_w;
  logic [N_CMP-1:0]     sel_src_w;
  logic [DATA_W-1:0]    view_w [N_VIEWS];
  logic [ADDR_W-1:0]    view_ofs_w;
  logic [2:0]           view_idx_w;
  logic                 view_hit_w;
  logic                 low_read_w;
  logic                 sel_clc_w;
  logic                 sel_excl_w;
  logic                 sel_cap_w;
  logic                 sel_cmcon_w;
  logic                 sel_sts_w;
  logic                 sel_mask_w;
  logic [N_CMP-1:0]     w1c_w;
  logic [DATA_W-1:0]    cmp_rd_w;
  logic [DATA_W-1:0]    src_rd_w;
  logic [DATA_W-1:0]    rd_mux_w;

  // The suspend pin is foreign to ref_clk; only the second stage is used.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      dbg_meta_q <= 1'b0;
      dbg_sync_q <= 1'b0;
    end else begin
      dbg_meta_q <= dbg_suspend;
      dbg_sync_q <= dbg_meta_q;
    end
  end

  // Address decode.
  assign sel_clc_w   = bus.addr == OFS_CLC;
  assign sel_excl_w  = bus.addr == OFS_EXCL;
  assign sel_cap_w   = bus.addr == OFS_CAP;
  assign sel_cmcon_w = bus.addr == OFS_CMCON;
  assign sel_sts_w   = bus.addr == OFS_STS;
  assign sel_mask_w  = bus.addr == OFS_MASK;
  assign view_ofs_w  = bus.addr - OFS_VIEW0;
  assign view_idx_w  = 3'(view_ofs_w >> 2);
  assign view_hit_w  = (bus.addr >= OFS_VIEW0) && (bus.addr <= OFS_VIEW6)
                       && (bus.addr[1:0] == 2'h0);
  assign low_read_w  = bus.rd && view_hit_w && (view_idx_w < 3'(N_VIEWS - 1));

  // Clock gating terms and the application reset qualifier.
  assign run_w = ~clc_q.dis & ~(clc_q.susp_en & dbg_sync_q);
  assign clr_w = app_rst & ~excl_q;

  wst_tick u_tick (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .run       (run_w),
    .full_rate (clc_q.full_rate),
    .tick      (tick_w)
  );

  // Counter: no start bit exists, so it runs from the first tick after reset.
  assign cnt_d = clr_w  ? '0 :
                 tick_w ? cnt_q + CNT_W'(1) :
                 cnt_q;

  // Capture holds the upper part seen in the same cycle as the low view read.
  assign cap_d = clr_w      ? '0 :
                 low_read_w ? cnt_q[CNT_W-1:CAP_SHIFT] :
                 cap_q;

  // Section views: the first six step four bits up each, the last shows the top 24 bits.
  genvar gv;
  generate
    for (gv = 0; gv < N_VIEWS; gv++) begin : g_view
      localparam int SH = (gv == N_VIEWS - 1) ? CAP_SHIFT : gv * VIEW_STEP;
      assign view_w[gv] = DATA_W'(cnt_q >> SH);
    end
  endgenerate

  // Compare channels with their registers and service request enables.
  genvar gc;
  generate
    for (gc = 0; gc < N_CMP; gc++) begin : g_cmp
      wst_cmp_cfg_s cfg_w;
      assign sel_cmp_w[gc] = bus.addr == ADDR_W'(OFS_CMP0 + gc * REG_STEP);
      assign sel_src_w[gc] = bus.addr == ADDR_W'(OFS_SRC0 + gc * REG_STEP);
      assign cfg_w.size    = cmcon_q[gc * CMCON_STRIDE +: SIZE_W];
      assign cfg_w.start   = cmcon_q[gc * CMCON_STRIDE + CMCON_START +: START_W];
      assign cmp_d[gc]     = clr_w ? '0 :
                             (bus.wr && sel_cmp_w[gc]) ? bus.wdata : cmp_q[gc];
      assign src_d[gc]     = (bus.wr && sel_src_w[gc]) ? bus.wdata[0] : src_q[gc];

      wst_cmp #(
        .CW (CNT_W),
        .DW (DATA_W)
      ) u_cmp (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .cnt     (cnt_q),
        .cmp_val (cmp_q[gc]),
        .cfg     (cfg_w),
        .evt     (evt_w[gc])
      );

      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          cmp_q[gc] <= '0;
        end else begin
          cmp_q[gc] <= cmp_d[gc];
        end
      end
    end
  endgenerate

  // Status: a match in the cycle of its own clear still sets the bit.
  assign w1c_w   = (bus.wr && sel_sts_w) ? bus.wdata[N_CMP-1:0] : '0;
  assign sts_d   = clr_w ? evt_w : ((sts_q & ~w1c_w) | evt_w);
  assign mask_d  = clr_w ? '0 : (bus.wr && sel_mask_w) ? bus.wdata[N_CMP-1:0] : mask_q;
  assign cmcon_d = clr_w ? CMCON_RESET : (bus.wr && sel_cmcon_w) ? bus.wdata : cmcon_q;

  // Clock control and exclusion bit ignore the application reset.
  assign clc_d  = (bus.wr && sel_clc_w) ? wst_clc_s'(bus.wdata[$bits(wst_clc_s)-1:0]) : clc_q;
  assign excl_d = (bus.wr && sel_excl_w) ? bus.wdata[0] : excl_q;

  // Read mux; the halted flag sits above the clock control fields.
  assign cmp_rd_w = sel_cmp_w[1] ? cmp_q[1] : cmp_q[0];
  assign src_rd_w = DATA_W'(sel_src_w[1] ? src_q[1] : src_q[0]);
  assign rd_mux_w = view_hit_w        ? view_w[view_idx_w] :
                    sel_clc_w         ? DATA_W'({~run_w, clc_q}) :
                    sel_excl_w        ? DATA_W'(excl_q) :
                    sel_cap_w         ? DATA_W'(cap_q) :
                    (|sel_cmp_w)      ? cmp_rd_w :
                    sel_cmcon_w       ? cmcon_q :
                    sel_sts_w         ? DATA_W'(sts_q) :
                    sel_mask_w        ? DATA_W'(mask_q) :
                    (|sel_src_w)      ? src_rd_w :
                    '0;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q   <= '0;
      cap_q   <= '0;
      cmcon_q <= CMCON_RESET;
      sts_q   <= '0;
      mask_q  <= '0;
      src_q   <= '0;
      clc_q   <= CLC_RESET;
      excl_q  <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      cap_q   <= cap_d;
      cmcon_q <= cmcon_d;
      sts_q   <= sts_d;
      mask_q  <= mask_d;
      src_q   <= src_d;
      clc_q   <= clc_d;
      excl_q  <= excl_d;
    end
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= '0;
      irq_q   <= 1'b0;
      srq_q   <= '0;
    end else begin
      rdata_q <= bus.rd ? rd_mux_w : '0;
      irq_q   <= |(sts_q & mask_q);
      srq_q   <= evt_w & src_q;
    end
  end

  assign rd_data = rdata_q;
  assign irq     = irq_q;
  assign srq     = srq_q;

  // Checks.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  logic [2:0] age_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      age_q <= 3'h0;
    end else if (age_q != 3'h7) begin
      age_q <= age_q + 3'h1;
    end
  end

  property p_cnt_incr;
    (tick_w && !clr_w) |=> cnt_q == $past(cnt_q) + CNT_W'(1);
  endproperty
  a_cnt_incr: assert property (p_cnt_incr) else $error("counter did not step on tick");

  property p_autostart;
    (age_q == 3'h1 && run_w) |-> ##[1:4] (cnt_q != $past(cnt_q) || !run_w || clr_w);
  endproperty
  a_autostart: assert property (p_autostart) else $error("counter did not start");

  property p_app_clear;
    (app_rst && !excl_q) |=> (cnt_q == '0 && cap_q == '0 && cmp_q[0] == '0);
  endproperty
  a_app_clear: assert property (p_app_clear) else $error("app reset did not clear");

  property p_app_excl;
    (app_rst && excl_q && tick_w) |=> cnt_q == $past(cnt_q) + CNT_W'(1);
  endproperty
  a_app_excl: assert property (p_app_excl) else $error("excluded timer was cleared");

  property p_half_rate;
    (!clc_q.full_rate && !$past(clc_q.full_rate) && tick_w) |=> !tick_w;
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("tick too fast at half rate");

  property p_top_view;
    (bus.rd && bus.addr == OFS_VIEW6) |=> rd_data == DATA_W'($past(cnt_q) >> CAP_SHIFT);
  endproperty
  a_top_view: assert property (p_top_view) else $error("top view read wrong");

  property p_capture;
    (low_read_w && !clr_w) |=> cap_q == $past(cnt_q[CNT_W-1:CAP_SHIFT]);
  endproperty
  a_capture: assert property (p_capture) else $error("capture not loaded");

  property p_srq;
    (evt_w[0] && src_q[0]) |=> srq[0];
  endproperty
  a_srq: assert property (p_srq) else $error("service request missing");

  property p_disabled;
    (clc_q.dis ##1 !clr_w) |=> $stable(cnt_q);
  endproperty
  a_disabled: assert property (p_disabled) else $error("counter ran while off");

  property p_suspend;
    ((clc_q.susp_en && dbg_sync_q) ##1 !clr_w) |=> $stable(cnt_q);
  endproperty
  a_suspend: assert property (p_suspend) else $error("counter ran in suspend");

  property p_wrap;
    (&cnt_q && tick_w && !clr_w) |=> cnt_q == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");

  property p_irq;
    (|(sts_q & mask_q)) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_cov_srq;
    srq[0] ##[1:20] srq[1];
  endproperty
  c_cov_srq: cover property (p_cov_srq);

  property p_cov_cap;
    low_read_w ##1 (bus.rd && sel_cap_w);
  endproperty
  c_cov_cap: cover property (p_cov_cap);

  property p_cov_excl;
    app_rst && excl_q;
  endproperty
  c_cov_excl: cover property (p_cov_excl);

endmodule : wst_timer

// ---- test/wst_timer_test.sv ----
/*
  Self-checking bench for the wide system timer: reset values, count rates, section
  views, capture, application reset, stop modes, compare requests and the interrupt.
  Assumes wst_pkg and the design files are compiled first; one 100 MHz ref_clk.
*/
module wst_timer_test;
  timeunit 1ns;
  timeprecision 1ps;
  import wst_pkg::*;

  typedef struct {
    logic [DATA_W-1:0] exp;
    logic [DATA_W-1:0] msk;
  } wst_note_s;

  logic              ref_clk;
  logic              rstn;
  wst_bus_s          bus;
  logic              app_rst;
  logic              dbg_suspend;
  logic [DATA_W-1:0] rd_data;
  logic              irq;
  logic [N_CMP-1:0]  srq;
  logic              rd_d;
  logic [DATA_W-1:0] last_rd;
  wst_note_s         notes[$];
  int                fails;
  int                checked;
  logic [DATA_W-1:0] a;
  logic [DATA_W-1:0] b;
  logic [DATA_W-1:0] v;
  logic [DATA_W-1:0] rnd;
  bit                seen;

  wst_timer u_wst_timer (
    .ref_clk     (ref_clk),
    .rstn        (rstn),
    .bus         (bus),
    .app_rst     (app_rst),
    .dbg_suspend (dbg_suspend),
    .rd_data     (rd_data),
    .irq         (irq),
    .srq         (srq)
  );

  always #5 ref_clk = ~ref_clk;

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
                     input string what);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  // Read data is only valid in the cycle after the strobe, so it is taken at the
  // falling edge of that cycle; a note with an empty mask is a read kept for relations.
  always @(posedge ref_clk) rd_d <= bus.rd;

  always @(negedge ref_clk) begin
    wst_note_s n;
    if (rd_d) begin
      last_rd = rd_data;
      n = notes.pop_front();
      if (n.msk != '0) begin
        chk(rd_data & n.msk, n.exp, "read data");
      end
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  task automatic wr(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    bus.addr  <= ad;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] e,
                    input logic [DATA_W-1:0] m, output logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    bus.addr <= ad;
    bus.rd   <= 1'b1;
    notes.push_back('{exp: e, msk: m});
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    @(negedge ref_clk);
    #1;
    d = last_rd;
  endtask : rd

  task automatic rde(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] e);
    logic [DATA_W-1:0] d;
    rd(ad, e, '1, d);
  endtask : rde

  task automatic pulse_app_rst;
    @(posedge ref_clk);
    app_rst <= 1'b1;
    @(posedge ref_clk);
    app_rst <= 1'b0;
  endtask : pulse_app_rst

  // Two view reads whose sampling edges lie exactly 20 cycles apart; an even gap
  // makes the half-rate step independent of the tick phase.
  task automatic rate_chk(input logic [DATA_W-1:0] step);
    cyc(4);
    rd(OFS_VIEW0, '0, '0, a);
    cyc(18);
    rd(OFS_VIEW0, '0, '0, b);
    chk(b - a, step, "count step");
  endtask : rate_chk

  task automatic cmp_chk(input int c, input logic [DATA_W-1:0] cfg,
                         input logic [DATA_W-1:0] val);
    logic [DATA_W-1:0] bit_c;
    bit_c = 32'h1 << c;
    wr(OFS_CMCON, cfg);
    wr(OFS_CMP0 + ADDR_W'(4 * c), val);
    wr(OFS_SRC0 + ADDR_W'(4 * c), 32'h1);
    wr(OFS_STS, 32'h3);
    seen = 1'b0;
    for (int i = 0; i < 400 && !seen; i++) begin
      @(negedge ref_clk);
      seen = (srq[c] === 1'b1);
    end
    chk({31'h0, seen}, 32'h1, "service request");
    chk({31'h0, irq}, 32'h0, "masked irq");
    rde(OFS_STS, bit_c);
    wr(OFS_MASK, bit_c);
    cyc(2);
    chk({31'h0, irq}, 32'h1, "unmasked irq");
    wr(OFS_STS, bit_c);
    cyc(2);
    chk({31'h0, irq}, 32'h0, "cleared irq");
    wr(OFS_MASK, 32'h0);
    wr(OFS_SRC0 + ADDR_W'(4 * c), 32'h0);
  endtask : cmp_chk

  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    $display("BAD watchdog expected finish seen timeout");
    stop_test();
  end

  initial begin
    ref_clk     = 1'b0;
    rstn        = 1'b0;
    bus         = '0;
    app_rst     = 1'b0;
    dbg_suspend = 1'b0;
    rd_d        = 1'b0;
    fails       = 0;
    checked     = 0;
    void'($urandom(32'h94c9));
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;

    rde(OFS_CLC, 32'(CLC_RESET));
    rde(OFS_CMCON, CMCON_RESET);
    rde(OFS_MASK, 32'h0);
    rde(OFS_EXCL, 32'h0);
    wr(8'h80, 32'hffff_ffff);
    rde(8'h80, 32'h0);
    $display("test reset done");

    rate_chk(32'ha);
    wr(OFS_CLC, 32'h4);
    rate_chk(32'h14);
    rde(OFS_CLC, 32'h4);
    $display("test rate done");

    wr(OFS_CLC, 32'h6);
    @(posedge ref_clk);
    dbg_suspend <= 1'b1;
    cyc(6);
    rate_chk(32'h0);
    rde(OFS_CLC, 32'he);
    @(posedge ref_clk);
    dbg_suspend <= 1'b0;
    cyc(6);
    rate_chk(32'h14);
    wr(OFS_CLC, 32'h0);
    rate_chk(32'ha);
    wr(OFS_CLC, 32'h5);
    rate_chk(32'h0);
    rde(OFS_CLC, 32'hd);
    $display("test stop done");

    rd(OFS_VIEW0, '0, '0, v);
    for (int k = 1; k < 6; k++) begin
      rde(OFS_VIEW0 + ADDR_W'(4 * k), v >> (4 * k));
    end
    rde(OFS_VIEW6, 32'h0);
    rde(OFS_CAP, 32'h0);
    wr(OFS_VIEW0, ~v);
    rde(OFS_VIEW0, v);
    $display("test views done");

    wr(OFS_CLC, 32'h4);
    rnd = $urandom;
    wr(OFS_CMCON, rnd);
    wr(OFS_EXCL, 32'h1);
    cyc(4);
    rd(OFS_VIEW0, '0, '0, a);
    pulse_app_rst();
    rd(OFS_VIEW0, '0, '0, b);
    chk({31'h0, b > a}, 32'h1, "excluded counter");
    rde(OFS_CMCON, rnd);
    wr(OFS_EXCL, 32'h0);
    pulse_app_rst();
    rd(OFS_VIEW0, '0, '0, b);
    chk({31'h0, b < 32'h8}, 32'h1, "cleared counter");
    rde(OFS_CMCON, CMCON_RESET);
    rde(OFS_CLC, 32'h4);
    rde(OFS_SRC0, 32'h0);
    $display("test app reset done");

    rd(OFS_VIEW0, '0, '0, a);
    cmp_chk(0, CMCON_RESET, a + 32'h3c);
    cmp_chk(1, 32'h0403_001f, $urandom);
    $display("test compare done");
    stop_test();
  end
endmodule : wst_timer_test
